// ---- src/svqf_pkg.sv ----
// package: register map, field positions and widths of the forwarding block
package svqf_pkg;
  localparam int          NPORT        = 3;
  localparam int          VLAN_DEPTH   = 16;
  localparam int          VID_W        = 12;
  localparam int          FID_W        = 4;
  localparam int          VENT_W       = 20;
  // register byte addresses
  localparam logic [7:0] A_GLOBAL     = 8'h05;
  localparam logic [7:0] A_PMAP_LO    = 8'h0C;
  localparam logic [7:0] A_PMAP_HI    = 8'h0D;
  localparam logic [7:0] A_PORT_BASE  = 8'h10;
  localparam logic [7:0] A_PORT_STEP  = 8'h10;
  localparam logic [7:0] A_OFF_CTRL0  = 8'h00;
  localparam logic [7:0] A_OFF_CTRL2  = 8'h02;
  localparam logic [7:0] A_OFF_TAGHI  = 8'h03;
  localparam logic [7:0] A_OFF_TAGLO  = 8'h04;
  localparam logic [7:0] A_DSCP_BASE  = 8'h60;
  localparam logic [7:0] A_DSCP_LAST  = 8'h67;
  localparam logic [7:0] A_INS_SEL    = 8'hC2;
  localparam logic [7:0] A_VT_D0      = 8'hF0;
  localparam logic [7:0] A_VT_D1      = 8'hF1;
  localparam logic [7:0] A_VT_D2      = 8'hF2;
  localparam logic [7:0] A_VT_WIDX    = 8'hF3;
  localparam logic [7:0] A_MODE       = 8'hF4;
  localparam logic [7:0] A_STATUS     = 8'hF5;
  // field positions
  localparam int B_WFQ       = 3;
  localparam int B_SPLIT     = 0;
  localparam int B_TAG_REM   = 1;
  localparam int B_TAG_INS   = 2;
  localparam int B_PPRIO_LO  = 3;
  localparam int B_P8021P    = 5;
  localparam int B_DSCP_EN   = 6;
  localparam int B_REMAP     = 7;
  localparam int B_DISC_NPV  = 5;
  localparam int B_ING_FILT  = 6;
  localparam int B_VLAN_EN   = 0;
  localparam int B_BYPASS    = 0;
  // vlan entry layout
  localparam int V_VID_LO    = 0;
  localparam int V_FID_LO    = 12;
  localparam int V_MEM_LO    = 16;
  localparam int V_VALID     = 19;
  // default tag fields inside the 16-bit tag
  localparam int T_PCP_LO    = 13;
  localparam logic [1:0] Q_TOP       = 2'h3;
  localparam logic [1:0] Q_BASE      = 2'h0;
  localparam logic [2:0] PORT_HOST   = 3'h4;
  localparam logic [2:0] PORT_ALL    = 3'h7;
  localparam logic [7:0] RST_BYTE    = 8'h00;
endpackage

// ---- src/svqf_top.sv ----
// forwarding, classification and egress tag decisions of a 3-port switch
// Behaviour
// - sleep pin high puts the switch into bypass, ports 1 and 2 still switch
// - in bypass, frames bound for port 3 are dropped before buffering
// - sixteen-entry table maps a 12-bit vid to a 4-bit filter group
// - untagged or null-vid frames use the ingress port default vid
// - vlan mode: invalid vid drops the frame and suppresses learning
// - static miss or group mismatch plus dynamic miss: vlan member ports
// - static hit with flag clear or group match: static entry port set
// - static table undecided and dynamic hit: the dynamic entry port
// - source miss adds a dynamic entry, source hit refreshes its stamp
// - per-port ingress filtering and non-default-vid discard
// - four queues per port, queue 3 highest, queue 0 lowest
// - per-port split bit; unsplit ports treat all priorities alike
// - global bit selects strict priority or weighted fair queuing
// - port-based priority field marks every frame of that port high
// - 802.1p enable maps tagged frame priority through a mapping table
// - tag insertion adds ingress default tag for selected source ports
// - already tagged frames never receive a second tag
// - tag removal strips the tag at egress; untagged frames pass
// - frame check sequence is recomputed after insertion or removal
// - priority above the default tag priority is lowered to it
// - dscp six bits select one bit of a 64-bit priority register
// - port 3 is the processor port, ports 1 and 2 face the network
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module svqf_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        host_port_tx_error_input_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_src_i,
  input  wire logic        req_tagged_i,
  input  wire logic [11:0] req_vid_i,
  input  wire logic [2:0]  req_pcp_i,
  input  wire logic        req_ip_i,
  input  wire logic [5:0]  req_dscp_i,
  input  wire logic        st_hit_i,
  input  wire logic        st_use_fid_i,
  input  wire logic [3:0]  st_fid_i,
  input  wire logic [2:0]  st_ports_i,
  input  wire logic        dyn_da_hit_i,
  input  wire logic [1:0]  dyn_port_i,
  input  wire logic        dyn_sa_hit_i,
  output logic             res_valid_o,
  output logic             res_drop_o,
  output logic      [2:0]  res_ports_o,
  output logic      [5:0]  res_queue_o,
  output logic      [2:0]  res_pcp_o,
  output logic      [2:0]  res_ins_o,
  output logic      [2:0]  res_rem_o,
  output logic      [2:0]  res_crc_o,
  output logic      [15:0] res_tag_o,
  output logic             learn_add_o,
  output logic             learn_refresh_o,
  output logic      [3:0]  filter_group_id_o,
  output logic             bypass_o,
  output logic             sched_wfq_o
);
  // port count is fixed by the register map, not a free parameter
  localparam int NP = svqf_pkg::NPORT;

  // all block state in one record: settings, sync flops, results
  typedef struct packed {
    logic [7:0]        global_r;
    logic [15:0]       pmap;
    logic [NP-1:0][7:0]  ctrl0;
    logic [NP-1:0][7:0]  ctrl2;
    logic [NP-1:0][15:0] dtag;
    logic [63:0]       dscp;
    logic [5:0]        ins_sel;
    logic [23:0]       vt_data;
    logic [7:0]        mode;
    logic              sync1;
    logic              sync2;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              rdrop;
    logic [2:0]        rports;
    logic [5:0]        rqueue;
    logic [2:0]        rpcp;
    logic [2:0]        rins;
    logic [2:0]        rrem;
    logic [2:0]        rcrc;
    logic [15:0]       rtag;
    logic              ladd;
    logic              lref;
    logic [3:0]        lfid;
  } svqf_state_t;

  svqf_state_t st_reg;
  svqf_state_t st_next;

  // vlan lookup outputs and settings of the ingress port
  logic        vt_hit;
  logic [3:0]  vt_fid;
  logic [2:0]  vt_mem;
  logic [11:0] look_vid;
  logic        vt_wr;
  logic [7:0]  port_ctl0;
  logic [7:0]  port_ctl2;
  logic [15:0] port_tag;

  // ingress port settings, port 3 (index 2) is the processor port
  // source index 3 is illegal and would read past the port arrays
  assign port_ctl0 = st_reg.ctrl0[req_src_i];
  assign port_ctl2 = st_reg.ctrl2[req_src_i];
  assign port_tag  = st_reg.dtag[req_src_i];
  // null vid and untagged frames fall back to the port default vid
  assign look_vid  = (!req_tagged_i || req_vid_i == '0) ?
                     port_tag[11:0] : req_vid_i;
  // the index write commits the staged entry at that same edge
  assign vt_wr     = wr_i && addr_i == svqf_pkg::A_VT_WIDX;

  // lookup is combinational, so the answer meets the request edge
  svqf_vlan_table #(
    .DEPTH (svqf_pkg::VLAN_DEPTH)
  ) u_vlan_table (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_i      (vt_wr),
    .widx_i    (wdata_i[3:0]),
    .wdata_i   (st_reg.vt_data[svqf_pkg::VENT_W-1:0]),
    .vid_i     (look_vid),
    .hit_o     (vt_hit),
    .fid_o     (vt_fid),
    .members_o (vt_mem)
  );

  // one combinational pass computes every next value of the state
  always_comb
  begin
    logic        vlan_on;
    logic        drop;
    logic [3:0]  filter_group_id;
    logic [2:0]  mem;
    logic [2:0]  dest;
    logic        st_ok;
    logic [1:0]  prio;
    logic [2:0]  pcp;
    logic [2:0]  ceil;
    logic [1:0]  k;
    logic [7:0]  pa;
    // defaults: admit, all ports members, lowest queue, pcp as received
    st_next  = st_reg;
    vlan_on  = st_reg.mode[svqf_pkg::B_VLAN_EN];
    drop     = 1'b0;
    filter_group_id      = '0;
    mem      = svqf_pkg::PORT_ALL;
    dest     = '0;
    st_ok    = 1'b0;
    prio     = svqf_pkg::Q_BASE;
    pcp      = req_pcp_i;
    ceil     = port_tag[svqf_pkg::T_PCP_LO +: 3];
    k        = '0;
    pa       = '0;

    // sleep pin passes two flops; bypass follows it both ways
    // the pin is not timed to mclk_i, so only sync2 is ever decoded
    st_next.sync1 = host_port_tx_error_input_i;
    st_next.sync2 = st_reg.sync1;

    // register writes
    if (wr_i)
    begin
      // global, mapping, insert-select and vlan staging registers
      if (addr_i == svqf_pkg::A_GLOBAL)
        st_next.global_r = wdata_i;
      if (addr_i == svqf_pkg::A_PMAP_LO)
        st_next.pmap[7:0] = wdata_i;
      if (addr_i == svqf_pkg::A_PMAP_HI)
        st_next.pmap[15:8] = wdata_i;
      if (addr_i == svqf_pkg::A_INS_SEL)
        st_next.ins_sel = wdata_i[5:0];
      if (addr_i == svqf_pkg::A_VT_D0)
        st_next.vt_data[7:0] = wdata_i;
      if (addr_i == svqf_pkg::A_VT_D1)
        st_next.vt_data[15:8] = wdata_i;
      if (addr_i == svqf_pkg::A_VT_D2)
        st_next.vt_data[23:16] = wdata_i;
      if (addr_i == svqf_pkg::A_MODE)
        st_next.mode = wdata_i;
      if (addr_i >= svqf_pkg::A_DSCP_BASE && addr_i <= svqf_pkg::A_DSCP_LAST)
        st_next.dscp[addr_i[2:0]*8 +: 8] = wdata_i;
      // each port block repeats at a fixed step from the first one
      for (int p = 0; p < NP; p++)
      begin
        pa = svqf_pkg::A_PORT_BASE + 8'(p) * svqf_pkg::A_PORT_STEP;
        if (addr_i == pa + svqf_pkg::A_OFF_CTRL0)
          st_next.ctrl0[p] = wdata_i;
        if (addr_i == pa + svqf_pkg::A_OFF_CTRL2)
          st_next.ctrl2[p] = wdata_i;
        if (addr_i == pa + svqf_pkg::A_OFF_TAGHI)
          st_next.dtag[p][15:8] = wdata_i;
        if (addr_i == pa + svqf_pkg::A_OFF_TAGLO)
          st_next.dtag[p][7:0] = wdata_i;
      end
    end

    // register reads, data stand for exactly the next cycle
    st_next.rdata = svqf_pkg::RST_BYTE;
    // unmapped and write-only addresses read back as zero
    if (rd_i)
    begin
      case (addr_i)
        svqf_pkg::A_GLOBAL:  st_next.rdata = st_reg.global_r;
        svqf_pkg::A_PMAP_LO: st_next.rdata = st_reg.pmap[7:0];
        svqf_pkg::A_PMAP_HI: st_next.rdata = st_reg.pmap[15:8];
        svqf_pkg::A_INS_SEL: st_next.rdata = {2'h0, st_reg.ins_sel};
        svqf_pkg::A_VT_D0:   st_next.rdata = st_reg.vt_data[7:0];
        svqf_pkg::A_VT_D1:   st_next.rdata = st_reg.vt_data[15:8];
        svqf_pkg::A_VT_D2:   st_next.rdata = st_reg.vt_data[23:16];
        svqf_pkg::A_MODE:    st_next.rdata = st_reg.mode;
        svqf_pkg::A_STATUS:  st_next.rdata = {7'h00, st_reg.sync2};
        default:             st_next.rdata = svqf_pkg::RST_BYTE;
      endcase
      if (addr_i >= svqf_pkg::A_DSCP_BASE && addr_i <= svqf_pkg::A_DSCP_LAST)
        st_next.rdata = st_reg.dscp[addr_i[2:0]*8 +: 8];
      // port blocks decode after the fixed map and override it
      for (int p = 0; p < NP; p++)
      begin
        pa = svqf_pkg::A_PORT_BASE + 8'(p) * svqf_pkg::A_PORT_STEP;
        if (addr_i == pa + svqf_pkg::A_OFF_CTRL0)
          st_next.rdata = st_reg.ctrl0[p];
        if (addr_i == pa + svqf_pkg::A_OFF_CTRL2)
          st_next.rdata = st_reg.ctrl2[p];
        if (addr_i == pa + svqf_pkg::A_OFF_TAGHI)
          st_next.rdata = st_reg.dtag[p][15:8];
        if (addr_i == pa + svqf_pkg::A_OFF_TAGLO)
          st_next.rdata = st_reg.dtag[p][7:0];
      end
    end

    // vlan admission; outside vlan mode every port is a member, group 0
    if (vlan_on)
    begin
      filter_group_id = vt_fid;
      mem = vt_mem;
      if (!vt_hit)
        drop = 1'b1;
      // ingress filter: the source port must belong to the vlan
      if (port_ctl2[svqf_pkg::B_ING_FILT] && !vt_mem[req_src_i])
        drop = 1'b1;
      // discard frames whose lookup vid is not the port default
      if (port_ctl2[svqf_pkg::B_DISC_NPV] && look_vid != port_tag[11:0])
        drop = 1'b1;
    end

    // destination resolution, static table first
    st_ok = st_hit_i && (!st_use_fid_i || st_fid_i == filter_group_id);
    if (st_ok)
      dest = st_ports_i;
    else if (dyn_da_hit_i)
      dest = 3'(1) << dyn_port_i;
    else
      dest = mem;
    // a frame never leaves through the port it arrived on
    dest[req_src_i] = 1'b0;
    // bypass keeps ports 1 and 2 alive and never buffers port 3 traffic
    if (st_reg.sync2)
      dest = dest & ~svqf_pkg::PORT_HOST;
    // an empty mask after pruning means nothing is buffered
    if (dest == '0)
      drop = 1'b1;

    // priority ceiling against the ingress default tag
    // untagged frames carry no priority field for the ceiling to lower
    if (port_ctl0[svqf_pkg::B_REMAP] && req_tagged_i && req_pcp_i > ceil)
      pcp = ceil;

    // classification: port based over 802.1p over dscp
    // dscp only raises priority; a clear code-point bit keeps queue 0
    if (port_ctl0[svqf_pkg::B_PPRIO_LO +: 2] != 2'h0)
      prio = svqf_pkg::Q_TOP;
    else if (port_ctl0[svqf_pkg::B_P8021P] && req_tagged_i)
      prio = st_reg.pmap[{pcp, 1'b0} +: 2];
    else if (port_ctl0[svqf_pkg::B_DSCP_EN] && req_ip_i &&
             st_reg.dscp[req_dscp_i])
      prio = svqf_pkg::Q_TOP;

    // pulses return to zero on idle cycles; fields follow every cycle
    st_next.rvalid = req_valid_i;
    st_next.rdrop  = req_valid_i && drop;
    st_next.rports = (req_valid_i && !drop) ? dest : '0;
    st_next.rpcp   = pcp;
    st_next.rtag   = {pcp, port_tag[12:0]};
    st_next.lfid   = filter_group_id;
    // learning only for admitted vlans
    // filtered or empty-mask frames still learn their source
    st_next.ladd   = req_valid_i && !(vlan_on && !vt_hit) && !dyn_sa_hit_i;
    st_next.lref   = req_valid_i && !(vlan_on && !vt_hit) && dyn_sa_hit_i;

    // per egress port: queue, tag insertion and removal
    for (int e = 0; e < NP; e++)
    begin
      // an unsplit queue puts everything in one class
      st_next.rqueue[2*e +: 2] =
        st_reg.ctrl0[e][svqf_pkg::B_SPLIT] ? prio : svqf_pkg::Q_BASE;
      // insert-select holds two bits per egress port, one per source
      // k ranks the source among the two ports other than e
      k = (req_src_i < 2'(e)) ? req_src_i : 2'(req_src_i - 2'h1);
      st_next.rins[e] = st_next.rports[e] && !req_tagged_i &&
                        st_reg.ctrl0[e][svqf_pkg::B_TAG_INS] &&
                        st_reg.ins_sel[2*e + int'(k)];
      st_next.rrem[e] = st_next.rports[e] && req_tagged_i &&
                        st_reg.ctrl0[e][svqf_pkg::B_TAG_REM];
      // four bytes more or less invalidate the received check sequence
      st_next.rcrc[e] = st_next.rins[e] || st_next.rrem[e];
    end
  end

  // whole state registered together, cleared to defaults
  // one register for all state keeps reset and update in one place
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // every output is a field of the registered state, no logic after it
  assign rdata_o           = st_reg.rdata;
  assign res_valid_o       = st_reg.rvalid;
  assign res_drop_o        = st_reg.rdrop;
  assign res_ports_o       = st_reg.rports;
  assign res_queue_o       = st_reg.rqueue;
  assign res_pcp_o         = st_reg.rpcp;
  assign res_ins_o         = st_reg.rins;
  assign res_rem_o         = st_reg.rrem;
  assign res_crc_o         = st_reg.rcrc;
  assign res_tag_o         = st_reg.rtag;
  // learning strobes and group go to the address table outside
  assign learn_add_o       = st_reg.ladd;
  assign learn_refresh_o   = st_reg.lref;
  assign filter_group_id_o = st_reg.lfid;
  assign bypass_o          = st_reg.sync2;
  // scheduler mode goes to the egress arbiter as a level
  assign sched_wfq_o       = st_reg.global_r[svqf_pkg::B_WFQ];
endmodule

// ---- src/svqf_vlan_table.sv ----
// sixteen-entry vlan table: vid to filter group and member ports
`timescale 1ns/10ps
module svqf_vlan_table #(
  parameter int DEPTH = svqf_pkg::VLAN_DEPTH
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wr_i,
  input  wire logic [$clog2(DEPTH)-1:0]   widx_i,
  input  wire logic [svqf_pkg::VENT_W-1:0] wdata_i,
  input  wire logic [svqf_pkg::VID_W-1:0] vid_i,
  output logic                            hit_o,
  output logic [svqf_pkg::FID_W-1:0]      fid_o,
  output logic [svqf_pkg::NPORT-1:0]      members_o
);
  logic [svqf_pkg::VENT_W-1:0] ent_reg [DEPTH];

  // entries clear to invalid so no vid matches before software loads them
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        ent_reg[i] <= '0;
    end
    else if (wr_i)
    begin
      ent_reg[widx_i] <= wdata_i;
    end
  end

  // associative search, lowest matching index wins on duplicates
  always_comb
  begin
    hit_o     = 1'b0;
    fid_o     = '0;
    members_o = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (ent_reg[i][svqf_pkg::V_VALID] &&
          ent_reg[i][svqf_pkg::V_VID_LO +: svqf_pkg::VID_W] == vid_i)
      begin
        hit_o     = 1'b1;
        fid_o     = ent_reg[i][svqf_pkg::V_FID_LO +: svqf_pkg::FID_W];
        members_o = ent_reg[i][svqf_pkg::V_MEM_LO +: svqf_pkg::NPORT];
      end
    end
  end
endmodule

// ---- verification/svqf_checker.sv ----
// concurrent checks on the forwarding block ports
`timescale 1ns/10ps
module svqf_checker (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       host_port_tx_error_input_i,
  input wire logic       req_valid_i,
  input wire logic [1:0] req_src_i,
  input wire logic       req_tagged_i,
  input wire logic       res_drop_o,
  input wire logic [2:0] res_ports_o,
  input wire logic [2:0] res_ins_o,
  input wire logic [2:0] res_rem_o,
  input wire logic [2:0] res_crc_o,
  input wire logic       res_valid_o,
  input wire logic       bypass_o,
  input wire logic       sched_wfq_o
);
  wire logic pin = host_port_tx_error_input_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // pin held three edges must have moved the bypass flag
  AST_SLEEP: assert property (pin [*3] |=> bypass_o)
    else $error("bypass not entered");
  AST_WAKE: assert property (!pin [*3] |=> !bypass_o)
    else $error("bypass not left");
  // bypass steady over request and result: port 3 never chosen
  AST_NO_HOST: assert property (bypass_o && $past(bypass_o) && res_valid_o
    |-> !res_ports_o[2]) else $error("port 3 chosen in bypass");
  AST_DROP: assert property (res_drop_o |-> res_ports_o == 3'h0)
    else $error("dropped frame has ports");
  AST_SRC: assert property (req_valid_i |=>
    !res_ports_o[$past(req_src_i)]) else $error("frame sent back");
  AST_WFQ: assert property (wr_i && addr_i == svqf_pkg::A_GLOBAL |=>
    sched_wfq_o == $past(wdata_i[3])) else $error("wfq not updated");
  AST_ONE_TAG: assert property (req_valid_i && req_tagged_i |=>
    res_ins_o == 3'h0) else $error("second tag inserted");
  AST_UNTAGGED: assert property (req_valid_i && !req_tagged_i |=>
    res_rem_o == 3'h0) else $error("untagged frame stripped");
  AST_FCS: assert property (res_valid_o |->
    res_crc_o == (res_ins_o | res_rem_o)) else $error("fcs flag wrong");
endmodule
bind svqf_top svqf_checker u_chk (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .host_port_tx_error_input_i, .req_valid_i, .req_src_i, .req_tagged_i,
  .res_drop_o, .res_ports_o, .res_ins_o, .res_rem_o, .res_crc_o,
  .res_valid_o, .bypass_o, .sched_wfq_o);

// ---- verification/svqf_tbl_model.sv ----
// address-table partner: static entries, learned dynamic entries
`timescale 1ns/10ps
module svqf_tbl_model (
  input  wire logic       mclk_i,
  input  wire logic [2:0] da_i,
  input  wire logic [2:0] sa_i,
  input  wire logic       add_i,
  output logic            st_hit_o,
  output logic            st_use_o,
  output logic [3:0]      st_fid_o,
  output logic [2:0]      st_ports_o,
  output logic            da_hit_o,
  output logic [1:0]      dport_o,
  output logic            sa_hit_o
);
  logic [7:0] known = 8'h00;
  logic [2:0] sa_q  = 3'h0;
  // keys 4..7 sit in the static table, the rest fall through
  assign st_hit_o   = da_i[2];
  assign st_use_o   = da_i[1];
  assign st_fid_o   = da_i[0] ? 4'h3 : 4'h2;
  assign st_ports_o = da_i ^ 3'h5;
  assign da_hit_o   = known[da_i];
  assign dport_o    = (da_i[1:0] == 2'h3) ? 2'h2 : da_i[1:0];
  assign sa_hit_o   = known[sa_i];
  // a learned source is only known from the second request after it on
  always @(posedge mclk_i)
  begin
    sa_q <= sa_i;
    if (add_i)
      known[sa_q] <= 1'b1;
  end
endmodule

// ---- verification/svqf_top_tb.sv ----
// random decision traffic checked against a behavioural model
`timescale 1ns/10ps
module svqf_top_tb;
  logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        pin = 1'b0, req_valid_i = 1'b0, req_tagged_i = 1'b0;
  logic        req_ip_i = 1'b0, pend = 1'b0, sleep = 1'b0, vmode;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, isel, rdata_o;
  logic [1:0]  req_src_i = 2'h0, dyn_port_i, xl;
  logic [11:0] req_vid_i = 12'h000;
  logic [2:0]  req_pcp_i = 3'h0, da = 3'h0, sa = 3'h0, st_ports_i;
  logic [5:0]  req_dscp_i = 6'h00, res_queue_o, xq, xm;
  logic [2:0]  res_ports_o, res_pcp_o, res_ins_o, res_rem_o, xp, xi, xr, xc;
  logic [3:0]  st_fid_i, filter_group_id_o, xf;
  logic [15:0] pmap, res_tag_o, xg;
  logic [63:0] dscp;
  logic        st_hit_i, st_use_fid_i, dyn_da_hit_i, dyn_sa_hit_i;
  logic        res_valid_o, res_drop_o, learn_add_o, learn_refresh_o;
  logic        bypass_o, sched_wfq_o, xinv, xd, xt;
  logic [7:0]  c0 [3], c2 [3];
  logic [15:0] dtag [3];
  logic [11:0] vt [4] = '{12'h000, 12'h005, 12'h009, 12'h007};
  int          n_errors = 0, cmp_count = 0;

  // design and its address-table partner
  svqf_top dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .host_port_tx_error_input_i(pin), .req_valid_i, .req_src_i,
    .req_tagged_i, .req_vid_i, .req_pcp_i, .req_ip_i, .req_dscp_i,
    .st_hit_i, .st_use_fid_i, .st_fid_i, .st_ports_i, .dyn_da_hit_i,
    .dyn_port_i, .dyn_sa_hit_i, .res_valid_o, .res_drop_o, .res_ports_o,
    .res_queue_o, .res_pcp_o, .res_ins_o, .res_rem_o, .res_crc_o(),
    .res_tag_o, .learn_add_o, .learn_refresh_o, .filter_group_id_o,
    .bypass_o, .sched_wfq_o);
  svqf_tbl_model peer (.mclk_i, .da_i(da), .sa_i(sa), .add_i(learn_add_o),
    .st_hit_o(st_hit_i), .st_use_o(st_use_fid_i), .st_fid_o(st_fid_i),
    .st_ports_o(st_ports_i), .da_hit_o(dyn_da_hit_i),
    .dport_o(dyn_port_i), .sa_hit_o(dyn_sa_hit_i));

  always #20 mclk_i = ~mclk_i;

  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus master: one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, exp);
  endtask

  // staged entry {valid, members} committed by the index write
  task automatic vent(input logic [3:0] i, input logic [11:0] v,
                      input logic [3:0] f, input logic [3:0] m);
    wr(8'hF0, v[7:0]);
    wr(8'hF1, {f, v[11:8]});
    wr(8'hF2, {4'h0, m});
    wr(8'hF3, {4'h0, i});
  endtask

  // random port, priority, insert-select and code-point settings
  task automatic cfg();
    logic [7:0] b;
    for (int p = 0; p < 3; p++)
    begin
      b = 8'h10 + 8'(p * 16);
      c0[p] = 8'($urandom);
      dtag[p] = {3'($urandom), 1'b0, vt[1 + $urandom % 3]};
      wr(b, c0[p]);
      wr(b + 8'h03, dtag[p][15:8]);
      wr(b + 8'h04, dtag[p][7:0]);
      c2[p] = {1'b0, 2'($urandom), 5'h00};
      wr(b + 8'h02, c2[p]);
    end
    pmap = 16'($urandom);
    isel = 8'($urandom);
    dscp = {$urandom, $urandom};
    wr(8'h0C, pmap[7:0]);
    wr(8'h0D, pmap[15:8]);
    wr(8'hC2, isel);
    for (int i = 0; i < 8; i++)
      wr(8'h60 + 8'(i), dscp[8*i +: 8]);
    b = {4'h0, 1'($urandom), 3'h0};
    wr(8'h05, b);
    rd(8'h05, b);
  endtask

  // back-to-back requests, one every cycle
  task automatic send(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      req_valid_i  <= 1'b1;
      req_src_i    <= 2'($urandom % 3);
      req_tagged_i <= 1'($urandom);
      req_vid_i    <= vt[$urandom % 4];
      {req_pcp_i, req_ip_i, req_dscp_i, da, sa} <= 16'($urandom);
    end
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    // idle edge: callers never change settings under a request
    @(posedge mclk_i);
  endtask

  function automatic logic [7:0] vlook(input logic [11:0] v);
    if (!vmode)
      return 8'h87;
    if (v == 12'h005)
      return 8'h9F;
    if (v == 12'h009)
      return 8'h93;
    return 8'h00;
  endfunction

  // compares last edge's expectation, then forms one for this edge
  always @(posedge mclk_i)
  begin : model
    logic [11:0] v;
    logic [7:0]  ve;
    logic [2:0]  d;
    logic [1:0]  q;
    int          s;
    if (rst_i)
      pend = 1'b0;
    else
    begin
      chk(res_valid_o, pend);
      if (pend)
      begin
        chk(res_ports_o, xp);
        chk(res_drop_o, xd);
        chk({learn_add_o, learn_refresh_o}, xl);
        if (!xinv) chk(filter_group_id_o, xf);
        chk(res_ins_o & xp, xi);
        chk(res_rem_o & xp, xr);
        chk(res_queue_o & xm, xq);
        chk(res_pcp_o, xc);
        chk(res_tag_o, xg);
      end
      pend = req_valid_i;
      s = req_src_i;
      v = (!req_tagged_i || req_vid_i == 12'h000) ? dtag[s][11:0] : req_vid_i;
      ve = vlook(v);
      xinv = !ve[7];
      xf = ve[6:3];
      if (st_hit_i && (!st_use_fid_i || st_fid_i == xf))
        d = st_ports_i;
      else if (dyn_da_hit_i)
        d = 3'h1 << dyn_port_i;
      else
        d = ve[2:0];
      d[s] = 1'b0;
      if (sleep)
        d[2] = 1'b0;
      xd = xinv || d == 3'h0 || (vmode && c2[s][6] && !ve[s]) ||
           (vmode && c2[s][5] && v != dtag[s][11:0]);
      xp = xd ? 3'h0 : d;
      xl = xinv ? 2'h0 : (dyn_sa_hit_i ? 2'h1 : 2'h2);
      xt = req_tagged_i;
      xc = req_pcp_i;
      if (c0[s][7] && xt && xc > dtag[s][15:13])
        xc = dtag[s][15:13];
      xg = {xc, dtag[s][12:0]};
      if (c0[s][4:3] != 2'h0)
        q = 2'h3;
      else if (c0[s][5] && xt)
        q = pmap[2*xc +: 2];
      else if (c0[s][6] && req_ip_i)
        q = dscp[req_dscp_i] ? 2'h3 : 2'h0;
      else
        q = 2'h0;
      {xq, xm, xi, xr} = 18'h00000;
      for (int e = 0; e < 3; e++)
        if (xp[e])
        begin
          xm[2*e +: 2] = 2'h3;
          xq[2*e +: 2] = c0[e][0] ? q : 2'h0;
          xi[e] = c0[e][2] && !xt && isel[2*e + ((s < e) ? s : s - 1)];
          xr[e] = c0[e][1] && xt;
        end
    end
  end

  // watchdog against a hung run
  initial
  begin
    #(40 * 20000);
    n_errors++;
    finish_test();
  end

  // rounds: awake, sleeping, awake without vlan mode, vlan again
  initial
  begin
    void'($urandom(32'h064a8f44));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(8'h10, 8'h00);
    rd(8'hEE, 8'h00);
    vent(4'h0, 12'h005, 4'h3, 4'hF);
    vent(4'h1, 12'h009, 4'h2, 4'hB);
    vent(4'h2, 12'h007, 4'h1, 4'h7);
    for (int r = 0; r < 6; r++)
    begin
      if (r == 2 || r == 4)
      begin
        sleep = (r == 2);
        pin <= sleep;
        repeat (6) @(posedge mclk_i);
        chk(bypass_o, sleep);
        rd(8'hF5, {7'h00, sleep});
      end
      vmode = (r != 4);
      wr(8'hF4, {7'h00, vmode});
      cfg();
      send(200);
    end
    finish_test();
  end
endmodule
